// ---- verilog/dsx_defs.vh ----
/*
 * constants of the strobe polarity / transfer block: widths, timing,
 * read burst shape.
 * assumes a 25 MHz ref_clk; included by bare name.
 */
`ifndef DSX_DEFS_VH
`define DSX_DEFS_VH

`define DSX_DQ_W 8
`define DSX_FIFO_DEPTH 32
`define DSX_FIFO_AW 5
`define DSX_CLK_NS 40
// beats of one read burst, both strobe edges counted
`define DSX_BURST_LEN 8
`define DSX_BEAT_W 4
// longest wait from read start to preamble, rounded down
`define DSX_PRE_TMO_NS 2000
`define DSX_PRE_TMO_CYC (`DSX_PRE_TMO_NS / `DSX_CLK_NS)
`define DSX_TMO_W 8
// edge clock period measurement
`define DSX_PER_W 8
`define DSX_PER_MAX 8'hFF

`define DSX_ST_IDLE 2'h0
`define DSX_ST_ARM 2'h1
`define DSX_ST_BURST 2'h2

`endif

// ---- verilog/dsx_fifo.v ----
/*
 * small synchronous fifo, valid/ready on both sides, registered read data.
 * assumes one clock and an asynchronous active high reset.
 */
module dsx_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_ff;
reg [AW-1:0] rd_ptr_ff;
reg [AW:0] cnt_ff;
reg [WIDTH-1:0] out_data_ff;
reg out_valid_ff;
wire push;
wire pop;

// the output register is one of the DEPTH words, so full means DEPTH total
assign in_ready = (cnt_ff + {{AW{1'b0}}, out_valid_ff}) != DEPTH[AW:0];
assign push = in_valid && in_ready;
// memory drains into the output register whenever it is free
assign pop = (cnt_ff != {(AW+1){1'b0}}) && (!out_valid_ff || out_ready);
assign out_valid = out_valid_ff;
assign out_data = out_data_ff;

always @(posedge clk) begin
   if (push) begin
      mem[wr_ptr_ff] <= in_data;
   end
end

always @(posedge clk or posedge rst) begin
   if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      out_data_ff <= {WIDTH{1'b0}};
      out_valid_ff <= 1'b0;
   end else begin
      if (push) begin
         wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
         rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
         out_data_ff <= mem[rd_ptr_ff];
         out_valid_ff <= 1'b1;
      end else if (out_ready) begin
         out_valid_ff <= 1'b0;
      end
      if (push && !pop) begin
         cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
         cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
      end
   end
end

endmodule

// ---- verilog/dsx_xfer.v ----
/*
 * read capture with per-read polarity choice, and a shared quarter-period
 * shifted write strobe for the whole data bus.
 * assumes strobe, data and edge clock arrive asynchronously to ref_clk and
 * are each much slower than it; the bench drives pins from the enables.
 */
// Functional notes
// R1: read data enters ref_clk domain through registers of selectable polarity.
// R2: polarity is chosen anew at the start of every read.
// R3: memory leaves the strobe undriven before a read begins.
// R4: memory drives the strobe low at the start of the preamble.
// R5: idle-to-low strobe transition is detected and sets the polarity.
// R6: output buffers get a write strobe shifted by a quarter period.
// R7: the shifted strobe comes from one shared strobe delay block.
// R8: every data output buffer receives the same shifted strobe.
// R9: the shift delay offsets the edge clock by a quarter period.
// R10: polarity holds for the burst; detector re-arms after the burst.
`include "dsx_defs.vh"

module dsx_xfer (
   input wire ref_clk,
   input wire rst,
   input wire dqs_pin_in,
   output wire dqs_pin_out,
   output wire dqs_pin_oe,
   input wire [`DSX_DQ_W-1:0] dq_pin_in,
   output wire [`DSX_DQ_W-1:0] dq_pin_out,
   output wire [`DSX_DQ_W-1:0] dq_pin_oe,
   input wire edge_clock_one,
   output wire [`DSX_DQ_W-1:0] write_strobe_shifted,
   input wire rd_start,
   output wire rd_busy,
   output wire rd_pol,
   output wire rd_timeout,
   output wire fifo_in_ready,
   output wire rd_valid,
   input wire rd_ready,
   output wire [`DSX_DQ_W-1:0] rd_data,
   input wire wr_en,
   input wire [`DSX_DQ_W-1:0] wr_data
);

////////////////////////////////////////////////////////////////////////////
// functions

// agreed level after a three-stage synchroniser
function filt;
   input prev;
   input s2;
   input s3;
   begin
      filt = (s2 == s3) ? s3 : prev;
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers

reg dqs_s1_ff;
reg dqs_s2_ff;
reg dqs_s3_ff;
reg dqs_ff;
reg ec_s1_ff;
reg ec_s2_ff;
reg ec_s3_ff;
reg ec_ff;
reg [`DSX_DQ_W-1:0] dq_s1_ff;
reg [`DSX_DQ_W-1:0] dq_s2_ff;
reg [`DSX_DQ_W-1:0] dq_s3_ff;
reg [`DSX_DQ_W-1:0] dq_s4_ff;
wire nxt_dqs;
wire nxt_ec;

assign nxt_dqs = filt(dqs_ff, dqs_s2_ff, dqs_s3_ff);
assign nxt_ec = filt(ec_ff, ec_s2_ff, ec_s3_ff);

always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      dqs_s1_ff <= 1'b1;
      dqs_s2_ff <= 1'b1;
      dqs_s3_ff <= 1'b1;
      dqs_ff <= 1'b1;
      ec_s1_ff <= 1'b0;
      ec_s2_ff <= 1'b0;
      ec_s3_ff <= 1'b0;
      ec_ff <= 1'b0;
      dq_s1_ff <= {`DSX_DQ_W{1'b0}};
      dq_s2_ff <= {`DSX_DQ_W{1'b0}};
      dq_s3_ff <= {`DSX_DQ_W{1'b0}};
      dq_s4_ff <= {`DSX_DQ_W{1'b0}};
   end else begin
      dqs_s1_ff <= dqs_pin_in;
      dqs_s2_ff <= dqs_s1_ff;
      dqs_s3_ff <= dqs_s2_ff;
      dqs_ff <= nxt_dqs;
      ec_s1_ff <= edge_clock_one;
      ec_s2_ff <= ec_s1_ff;
      ec_s3_ff <= ec_s2_ff;
      ec_ff <= nxt_ec;
      dq_s1_ff <= dq_pin_in;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
      dq_s4_ff <= dq_s3_ff;
   end
end

// either strobe edge marks one data beat
wire dqs_edge;
wire dqs_fall;
assign dqs_edge = (nxt_dqs != dqs_ff);
assign dqs_fall = dqs_ff && !nxt_dqs;

////////////////////////////////////////////////////////////////////////////
// read control

reg [1:0] state_ff;
reg [1:0] nxt_state;
reg pol_ff;
reg nxt_pol;
reg seen_idle_ff;
reg nxt_seen_idle;
reg [`DSX_TMO_W-1:0] tmo_ff;
reg [`DSX_TMO_W-1:0] nxt_tmo;
reg [`DSX_BEAT_W-1:0] beat_ff;
reg [`DSX_BEAT_W-1:0] nxt_beat;
reg tmo_pulse_ff;
reg nxt_tmo_pulse;
reg cap_ff;
reg nxt_cap;
wire fifo_ready;
reg wr_act_ff;

always @* begin
   nxt_state = state_ff;
   nxt_pol = pol_ff;
   nxt_seen_idle = seen_idle_ff;
   nxt_tmo = tmo_ff;
   nxt_beat = beat_ff;
   nxt_tmo_pulse = 1'b0;
   nxt_cap = 1'b0;
   case (state_ff)
      `DSX_ST_IDLE: begin
         // room in the fifo, and no write driving or about to drive the bus
         if (rd_start && fifo_ready && !wr_act_ff && !wr_en) begin
            nxt_state = `DSX_ST_ARM;
            nxt_seen_idle = 1'b0;
            nxt_tmo = {`DSX_TMO_W{1'b0}};
            nxt_pol = 1'b0; // [R2]
         end
      end
      `DSX_ST_ARM: begin
         nxt_tmo = tmo_ff + {{(`DSX_TMO_W-1){1'b0}}, 1'b1};
         if (dqs_ff) begin
            nxt_seen_idle = 1'b1;
         end
         // idle high level then driven low: the preamble has begun
         if (seen_idle_ff && dqs_fall) begin
            nxt_state = `DSX_ST_BURST;
            // strobe phase against ref_clk picks the capture edge
            nxt_pol = tmo_ff[0]; // [R5] [R1]
            nxt_beat = {`DSX_BEAT_W{1'b0}};
         end else if (tmo_ff == `DSX_PRE_TMO_CYC - 1) begin
            nxt_state = `DSX_ST_IDLE;
            nxt_tmo_pulse = 1'b1;
         end
      end
      `DSX_ST_BURST: begin
         // polarity stays fixed until the last beat is taken
         if (dqs_edge) begin // [R10]
            nxt_cap = 1'b1;
            nxt_beat = beat_ff + {{(`DSX_BEAT_W-1){1'b0}}, 1'b1};
            if (beat_ff == `DSX_BURST_LEN - 1) begin
               nxt_state = `DSX_ST_IDLE; // [R10]
            end
         end
      end
      default: begin
         nxt_state = `DSX_ST_IDLE;
      end
   endcase
end

always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      state_ff <= `DSX_ST_IDLE;
      pol_ff <= 1'b0;
      seen_idle_ff <= 1'b0;
      tmo_ff <= {`DSX_TMO_W{1'b0}};
      beat_ff <= {`DSX_BEAT_W{1'b0}};
      tmo_pulse_ff <= 1'b0;
      cap_ff <= 1'b0;
   end else begin
      state_ff <= nxt_state;
      pol_ff <= nxt_pol;
      seen_idle_ff <= nxt_seen_idle;
      tmo_ff <= nxt_tmo;
      beat_ff <= nxt_beat;
      tmo_pulse_ff <= nxt_tmo_pulse;
      cap_ff <= nxt_cap;
   end
end

////////////////////////////////////////////////////////////////////////////
// synchronising capture registers

// cap_ff lags the strobe edge by one cycle; dq_s3 then shows the beat,
// pol 1 takes the later copy to stay clear of the changing stage
reg [`DSX_DQ_W-1:0] beat_data_ff;
reg beat_vld_ff;

always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      beat_data_ff <= {`DSX_DQ_W{1'b0}};
      beat_vld_ff <= 1'b0;
   end else begin
      beat_vld_ff <= cap_ff;
      if (cap_ff) begin
         beat_data_ff <= pol_ff ? dq_s4_ff : dq_s3_ff; // [R1]
      end
   end
end

// a full fifo cannot stall the memory, so room is checked before a read
dsx_fifo #(
   .WIDTH(`DSX_DQ_W),
   .DEPTH(`DSX_FIFO_DEPTH),
   .AW(`DSX_FIFO_AW)
) u_fifo (
   .clk(ref_clk),
   .rst(rst),
   .in_valid(beat_vld_ff),
   .in_ready(fifo_ready),
   .in_data(beat_data_ff),
   .out_valid(rd_valid),
   .out_ready(rd_ready),
   .out_data(rd_data)
);

////////////////////////////////////////////////////////////////////////////
// strobe delay block: one shared quarter-period shifter

reg ec_d_ff;
reg [`DSX_PER_W-1:0] per_cnt_ff;
reg [`DSX_PER_W-1:0] quarter_ff;
reg [`DSX_PER_W-1:0] dly_ff;
reg pend_ff;
reg pend_lvl_ff;
reg shifted_ff;
wire ec_rise;
wire ec_chg;

assign ec_rise = ec_ff && !ec_d_ff;
assign ec_chg = (ec_ff != ec_d_ff);

always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      ec_d_ff <= 1'b0;
      per_cnt_ff <= {`DSX_PER_W{1'b0}};
      quarter_ff <= {{(`DSX_PER_W-1){1'b0}}, 1'b1};
      dly_ff <= {`DSX_PER_W{1'b0}};
      pend_ff <= 1'b0;
      pend_lvl_ff <= 1'b0;
      shifted_ff <= 1'b0;
   end else begin
      ec_d_ff <= ec_ff;
      if (ec_rise) begin
         per_cnt_ff <= {{(`DSX_PER_W-1){1'b0}}, 1'b1};
         // quarter of the measured period, never below one cycle
         if (per_cnt_ff[`DSX_PER_W-1:2] != {(`DSX_PER_W-2){1'b0}}) begin
            quarter_ff <= {2'b00, per_cnt_ff[`DSX_PER_W-1:2]}; // [R9]
         end
      end else if (per_cnt_ff != `DSX_PER_MAX) begin
         per_cnt_ff <= per_cnt_ff + {{(`DSX_PER_W-1){1'b0}}, 1'b1};
      end
      // every edge clock edge reappears a quarter period later
      if (ec_chg) begin
         pend_ff <= 1'b1;
         pend_lvl_ff <= ec_ff;
         dly_ff <= {{(`DSX_PER_W-1){1'b0}}, 1'b1};
      end else if (pend_ff) begin
         if (dly_ff == quarter_ff) begin
            pend_ff <= 1'b0;
            shifted_ff <= pend_lvl_ff; // [R9] [R7]
         end else begin
            dly_ff <= dly_ff + {{(`DSX_PER_W-1){1'b0}}, 1'b1};
         end
      end
   end
end

// one strobe fanned to every data lane
assign write_strobe_shifted = {`DSX_DQ_W{shifted_ff}}; // [R6] [R8]

////////////////////////////////////////////////////////////////////////////
// write drive

reg [`DSX_DQ_W-1:0] wr_data_ff;

always @(posedge ref_clk or posedge rst) begin
   if (rst) begin
      wr_act_ff <= 1'b0;
      wr_data_ff <= {`DSX_DQ_W{1'b0}};
   end else begin
      // writes wait while a read owns the bus
      wr_act_ff <= wr_en && (state_ff == `DSX_ST_IDLE);
      wr_data_ff <= wr_data;
   end
end

// strobe released outside writes so the memory can own it on reads [R3]
assign dqs_pin_oe = wr_act_ff;
assign dqs_pin_out = shifted_ff; // [R6]
assign dq_pin_oe = {`DSX_DQ_W{wr_act_ff}};
assign dq_pin_out = wr_data_ff;

assign rd_busy = (state_ff != `DSX_ST_IDLE);
assign rd_pol = pol_ff;
assign rd_timeout = tmo_pulse_ff;
assign fifo_in_ready = fifo_ready;

endmodule

// ---- bench/dsx_xfer_monitor.sv ----
/* assertions on the ports of dsx_xfer, bound to it.
   assumes the bench's 320 ns edge clock. */
`include "dsx_defs.vh"
module dsx_xfer_monitor (
   input wire ref_clk,
   input wire rst,
   input wire rd_start,
   input wire rd_busy,
   input wire rd_pol,
   input wire rd_timeout,
   input wire fifo_in_ready,
   input wire wr_en,
   input wire [`DSX_DQ_W-1:0] wr_data,
   input wire [`DSX_DQ_W-1:0] dq_pin_out,
   input wire [`DSX_DQ_W-1:0] dq_pin_oe,
   input wire dqs_pin_oe,
   input wire edge_clock_one,
   input wire [`DSX_DQ_W-1:0] write_strobe_shifted
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [7:0] busy_cnt_ff;
   logic [2:0] ec_cnt_ff;
   logic ec_prev_ff;
   // a write that is driving the bus also blocks a read
   wire rd_take = rd_start && !rd_busy && fifo_in_ready && !wr_en &&
      !dqs_pin_oe;
   ////////////////////////////////////////////////////////////////////////
   // shift is only trusted once a few edge clock periods were measured
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_cnt_ff <= 8'h00;
         ec_cnt_ff <= 3'h0;
         ec_prev_ff <= 1'b0;
      end else begin
         busy_cnt_ff <= rd_busy ? busy_cnt_ff + 8'h01 : 8'h00;
         ec_prev_ff <= edge_clock_one;
         if (edge_clock_one && !ec_prev_ff && ec_cnt_ff != 3'h4)
            ec_cnt_ff <= ec_cnt_ff + 3'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   AST_RD_TAKE: assert property (rd_take |=> rd_busy)
      else $error("read request not taken");
   AST_POL_FRESH: assert property (rd_take |=> !rd_pol)
      else $error("polarity not cleared at read start");
   AST_POL_HOLD: assert property (rd_busy && rd_pol |=> rd_pol)
      else $error("polarity changed within burst");
   AST_POL_IDLE: assert property (!rd_busy ##1 !rd_busy |-> $stable(rd_pol))
      else $error("polarity changed between reads");
   AST_PRE_TMO: assert property (rd_timeout |->
      busy_cnt_ff >= 8'h2D && busy_cnt_ff <= 8'h37 ##1 !rd_busy)
      else $error("preamble timeout off");
   AST_BUSY_END: assert property ($rose(rd_busy) |-> ##[1:300] !rd_busy)
      else $error("read never ends");
   AST_RD_QUIET: assert property (rd_busy |-> !dqs_pin_oe)
      else $error("strobe driven during read");
   AST_WR_DRIVE: assert property (wr_en && !rd_busy |=> dqs_pin_oe &&
      dq_pin_oe == '1 && dq_pin_out == $past(wr_data))
      else $error("write not driven");
   AST_WR_OFF: assert property (!wr_en |=> dq_pin_oe == 0 && !dqs_pin_oe)
      else $error("bus not released");
   AST_WSS_LANES: assert property (write_strobe_shifted ==
      {`DSX_DQ_W{write_strobe_shifted[0]}})
      else $error("shifted strobe lanes differ");
   AST_WSS_SHIFT: assert property (ec_cnt_ff == 3'h4 &&
      $rose(edge_clock_one) |-> ##[3:7] $rose(write_strobe_shifted[0]))
      else $error("shifted strobe late or early");
endmodule
bind dsx_xfer dsx_xfer_monitor u_dsx_xfer_monitor (.ref_clk(ref_clk),
   .rst(rst), .rd_start(rd_start), .rd_busy(rd_busy), .rd_pol(rd_pol),
   .rd_timeout(rd_timeout), .fifo_in_ready(fifo_in_ready), .wr_en(wr_en),
   .wr_data(wr_data), .dq_pin_out(dq_pin_out), .dq_pin_oe(dq_pin_oe),
   .dqs_pin_oe(dqs_pin_oe), .edge_clock_one(edge_clock_one),
   .write_strobe_shifted(write_strobe_shifted));

// ---- bench/dsx_mem_model.sv ----
/* memory model driving strobe and data for one read burst.
   assumes the bench resolves the strobe pin from both enables and the data pins from dq_pin_oe alone. */
`include "dsx_defs.vh"
module dsx_mem_model (
   output logic dqs_drv,
   output logic dqs_en,
   output logic [`DSX_DQ_W-1:0] dq_drv
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      dqs_drv = 1'b1;
      dqs_en = 1'b0;
      dq_drv = 8'h00;
   end
   // data moves mid half period, 6 cycles clear of each strobe edge
   task automatic burst(input logic [63:0] w, input int pre);
      #pre;
      dqs_en = 1'b1;
      dqs_drv = 1'b0;
      for (int i = 0; i < `DSX_BURST_LEN; i++) begin
         #240 dq_drv = w[8*i +: 8];
         #240 dqs_drv = ~dqs_drv;
      end
      #240 dqs_en = 1'b0;
      dq_drv = ~dq_drv;
   endtask
endmodule

// ---- bench/tb_dsx_xfer.sv ----
/* self-checking bench of dsx_xfer: writes, reads, fifo fill, timeout.
   assumes a 32 word fifo and 8 beat bursts. */
`include "dsx_defs.vh"
module tb_dsx_xfer;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic edge_clock_one = 1'b0;
   logic rd_start = 1'b0;
   logic rd_ready = 1'b0;
   logic wr_en = 1'b0;
   logic [`DSX_DQ_W-1:0] wr_data = 8'h00;
   wire dqs_pin_out, dqs_pin_oe, rd_busy, rd_pol, rd_timeout;
   wire fifo_in_ready, rd_valid, mem_dqs, mem_en;
   wire [`DSX_DQ_W-1:0] dq_pin_out, dq_pin_oe, rd_data, mem_dq;
   wire [`DSX_DQ_W-1:0] write_strobe_shifted;
   int errors = 0;
   int checked = 0;
   // undriven strobe rests high through its termination
   wire dqs_pin_in = dqs_pin_oe ? dqs_pin_out : (mem_en ? mem_dqs : 1'b1);
   wire [`DSX_DQ_W-1:0] dq_pin_in = dq_pin_oe[0] ? dq_pin_out : mem_dq;
   always #20 ref_clk = ~ref_clk;
   always #160 edge_clock_one = ~edge_clock_one;
   dsx_xfer u_dsx_xfer (.ref_clk(ref_clk), .rst(rst),
      .dqs_pin_in(dqs_pin_in), .dqs_pin_out(dqs_pin_out),
      .dqs_pin_oe(dqs_pin_oe), .dq_pin_in(dq_pin_in),
      .dq_pin_out(dq_pin_out), .dq_pin_oe(dq_pin_oe),
      .edge_clock_one(edge_clock_one),
      .write_strobe_shifted(write_strobe_shifted), .rd_start(rd_start),
      .rd_busy(rd_busy), .rd_pol(rd_pol), .rd_timeout(rd_timeout),
      .fifo_in_ready(fifo_in_ready), .rd_valid(rd_valid),
      .rd_ready(rd_ready), .rd_data(rd_data), .wr_en(wr_en),
      .wr_data(wr_data));
   dsx_mem_model u_dsx_mem_model (.dqs_drv(mem_dqs), .dqs_en(mem_en),
      .dq_drv(mem_dq));
   ////////////////////////////////////////////////////////////////////////
   task automatic step(input int n = 1);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task automatic chk(input bit ok, input string m);
      checked++;
      if (!ok) begin
         errors++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic pulse_start;
      rd_start = 1'b1;
      step();
      rd_start = 1'b0;
   endtask
   task automatic read_burst(input logic [63:0] w, input int pre);
      pulse_start();
      chk(rd_busy === 1'b1, "read not started");
      chk(rd_pol === 1'b0, "old polarity kept");
      u_dsx_mem_model.burst(w, pre);
      step(4);
      chk(rd_busy === 1'b0, "busy after burst");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_write;
      int rises;
      logic prev;
      wr_en = 1'b1;
      wr_data = 8'hA5;
      step();
      wr_data = 8'h3C;
      chk(dq_pin_oe === 8'hFF && dq_pin_out === 8'hA5, "no write");
      chk(dqs_pin_oe === 1'b1, "strobe not driven");
      pulse_start();
      chk(dq_pin_out === 8'h3C && rd_busy === 1'b0, "read in write");
      rises = 0;
      prev = write_strobe_shifted[0];
      repeat (24) begin
         step();
         chk(write_strobe_shifted === {8{prev}} ||
            write_strobe_shifted === {8{~prev}}, "lanes differ");
         rises += (write_strobe_shifted[0] === 1'b1 && prev === 1'b0);
         prev = write_strobe_shifted[0];
      end
      chk(rises == 3, "shifted strobe rate");
      wr_en = 1'b0;
      step();
      chk(dq_pin_oe === 8'h00 && dqs_pin_oe === 1'b0, "not released");
      $display("test write done");
   endtask
   // four bursts fill the fifo with the reader stalled, then drain it
   task automatic t_fill;
      logic [63:0] w;
      int n;
      for (int b = 0; b < 4; b++) begin
         for (int i = 0; i < 8; i++)
            w[8*i +: 8] = 8'(8 * b + i) ^ 8'hA5;
         read_burst(w, 400 + 40 * b);
      end
      chk(fifo_in_ready === 1'b0, "fifo not full");
      pulse_start();
      chk(rd_busy === 1'b0, "read taken while full");
      rd_ready = 1'b1;
      for (int j = 0; j < 32; j++) begin
         n = 0;
         while (rd_valid !== 1'b1 && n < 20) begin
            step();
            n++;
         end
         chk(rd_data === (8'(j) ^ 8'hA5), "read data");
         step();
      end
      step(2);
      chk(rd_valid === 1'b0, "fifo not empty");
      $display("test fill done");
   endtask
   task automatic t_timeout;
      int n;
      pulse_start();
      n = 1;
      while (rd_timeout !== 1'b1 && n < 80) begin
         step();
         n++;
      end
      chk(n >= 47 && n <= 55, "timeout span");
      step();
      chk(rd_busy === 1'b0, "busy after timeout");
      $display("test timeout done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      step(2);
      rst = 1'b0;
      chk(dq_pin_oe === 8'h00 && dqs_pin_oe === 1'b0, "oe after reset");
      chk(rd_busy === 1'b0 && rd_valid === 1'b0, "busy after reset");
      $display("test reset done");
      t_write();
      t_fill();
      t_timeout();
      wrap_up();
   end
   initial begin
      #300000;
      errors++;
      $display("mismatch at %0t: %s", $time, "watchdog");
      wrap_up();
   end
endmodule
